// *** bench/sequencer_step_config_tb.sv ***
// Self-checking testbench for the step seven configuration block.
// Assumes the design files are compiled first; the bench drives every input port except hready, which is tied to hreadyout.
`timescale 1ns/1ps
module sequencer_step_config_tb;

  // ==========================================================
  // Signals
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic        seq_step_req;
  logic        conv_done;
  logic        conv_start;
  logic        step_done;
  logic        step_skipped;
  logic        step_busy;
  logic [3:0]  pos_input_sel;
  logic        neg_v7_sel;
  logic        neg_auto_sel;
  logic        temp_sensor_sel;
  logic        ground_short_sel;
  logic        io_supply_sel;
  logic [1:0]  gain_log2;
  logic [31:0] rd;
  logic [31:0] wd;
  logic [15:0] c;
  logic [3:0]  last_pos;
  int          err_count;
  int          cmp_count;
  int          seed;
  int          i;

  localparam logic [31:0] CFG_ADDR  = 32'h0000_025C;
  localparam logic [31:0] STAT_ADDR = 32'h0000_0280;

  always #5 hclk = ~hclk;

  // ==========================================================
  // Design under test; the single slave drives the bus ready
  ssc_step7_top ssc_step7_top_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .seq_step_req(seq_step_req), .conv_done(conv_done), .conv_start(conv_start),
    .step_done(step_done), .step_skipped(step_skipped), .step_busy(step_busy),
    .pos_input_sel(pos_input_sel), .neg_v7_sel(neg_v7_sel), .neg_auto_sel(neg_auto_sel),
    .temp_sensor_sel(temp_sensor_sel), .ground_short_sel(ground_short_sel),
    .io_supply_sel(io_supply_sel), .gain_log2(gain_log2)
  );

  // ==========================================================
  // Checking and closing
  task check(input logic [31:0] got, input logic [31:0] exp, input string msg);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask : check

  task results;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : results

  function automatic logic [1:0] exp_gain(input logic [1:0] g);
    return (g == 2'b00) ? 2'b00 : (g == 2'b01) ? 2'b01 : 2'b10;
  endfunction : exp_gain

  // ==========================================================
  // Bus master
  task wait_ready;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) begin
      err_count++;
      $display("unexpected at %0t: bus ready never came", $time);
      results();
    end
  endtask : wait_ready

  task ahb(input logic [31:0] addr, input logic wr, input logic [31:0] wdat,
           output logic [31:0] rdat);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= addr;
    hwrite <= wr;
    hsize  <= 3'b010;
    wait_ready();
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wdat;
    wait_ready();
    rdat = hrdata;
    check(32'(hresp), 32'h0000_0000, "bus response");
  endtask : ahb

  // ==========================================================
  // One step seven run with configuration cfg; an enabled step also gets a second request while busy
  task run_step(input logic [15:0] cfg);
    logic [3:0] p;
    p = cfg[3:0];
    seq_step_req <= 1'b1;
    @(posedge hclk);
    seq_step_req <= 1'b0;
    #1;
    if (cfg[15]) begin
      check(32'({conv_start, step_busy, step_done}), 32'h0000_0006, "start");
      check(32'(pos_input_sel), 32'(p), "positive select");
      check(32'(neg_v7_sel), 32'(p < 4'h8 ? cfg[4] : 1'b0), "negative select");
      check(32'(neg_auto_sel), 32'(p[3]), "auto negative");
      check(32'({temp_sensor_sel, ground_short_sel, io_supply_sel}),
            32'({p == 4'h8, p == 4'h9, p == 4'hC}), "internal source");
      check(32'(gain_log2), 32'(exp_gain(cfg[14:13])), "gain");
      last_pos = p;
      @(posedge hclk);
      seq_step_req <= 1'b1;
      @(posedge hclk);
      seq_step_req <= 1'b0;
      conv_done    <= 1'b1;
      #1;
      check(32'({conv_start, step_busy}), 32'h0000_0001, "request while busy");
      @(posedge hclk);
      conv_done <= 1'b0;
      #1;
      check(32'({step_done, step_skipped, step_busy}), 32'h0000_0004, "finish");
    end else begin
      check(32'({conv_start, step_busy, step_done, step_skipped}), 32'h0000_0003,
            "skip");
      check(32'(pos_input_sel), 32'(last_pos), "selection kept on skip");
    end
    @(posedge hclk);
  endtask : run_step

  // ==========================================================
  // Main sequence
  initial begin
    hclk         = 1'b0;
    hresetn      = 1'b0;
    hsel         = 1'b0;
    haddr        = 32'h0000_0000;
    htrans       = 2'b00;
    hwrite       = 1'b0;
    hsize        = 3'b010;
    hwdata       = 32'h0000_0000;
    seq_step_req = 1'b0;
    conv_done    = 1'b0;
    err_count    = 0;
    cmp_count    = 0;
    seed         = 60410;
    last_pos     = 4'h0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);

    ahb(CFG_ADDR, 1'b0, 32'h0000_0000, rd);
    check(rd, 32'h0000_0007, "config reset value");
    ahb(32'h0000_0300, 1'b1, 32'hFFFF_FFFF, rd);
    ahb(32'h0000_0300, 1'b0, 32'h0000_0000, rd);
    check(rd, 32'h0000_0000, "unmapped read");
    ahb(32'h0001_025C, 1'b0, 32'h0000_0000, rd);
    check(rd, 32'h0000_0000, "high address bits");
    run_step(16'h0007);
    $display("test reset and unmapped done");

    for (i = 0; i < 12; i++) begin
      wd = $random(seed);
      if (i == 0) begin
        wd = 32'hFFFF_FFFF;
      end
      ahb(CFG_ADDR, 1'b1, wd, rd);
      ahb(CFG_ADDR, 1'b0, 32'h0000_0000, rd);
      check(rd, wd & 32'h0000_E01F, "config readback");
    end
    $display("test register access done");

    for (i = 0; i < 32; i++) begin
      wd = $random(seed);
      c  = {1'b1, i[1:0], 8'h00, (i < 16) ? wd[0] : ~wd[0], i[3:0]};
      ahb(CFG_ADDR, 1'b1, {16'h0000, c}, rd);
      run_step(c);
    end
    $display("test enabled steps done");

    for (i = 0; i < 4; i++) begin
      wd = $random(seed);
      c  = wd[15:0] & 16'h601F;
      ahb(CFG_ADDR, 1'b1, {wd[31:16], c}, rd);
      run_step(c);
    end
    $display("test disabled steps done");

    ahb(STAT_ADDR, 1'b0, 32'h0000_0000, rd);
    check(rd, 32'h0002_0520, "status counts");
    ahb(CFG_ADDR, 1'b1, 32'h0000_800C, rd);
    seq_step_req <= 1'b1;
    @(posedge hclk);
    seq_step_req <= 1'b0;
    hresetn      <= 1'b0;
    @(posedge hclk);
    #1;
    check(32'({conv_start, step_busy, step_done, step_skipped, neg_v7_sel, neg_auto_sel,
               temp_sensor_sel, ground_short_sel, io_supply_sel, gain_log2, pos_input_sel}),
          32'h0000_0000, "outputs in reset");
    check(hrdata, 32'h0000_0000, "read data in reset");
    check(32'({hreadyout, hresp}), 32'h0000_0002, "bus in reset");
    @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    ahb(CFG_ADDR, 1'b0, 32'h0000_0000, rd);
    check(rd, 32'h0000_0007, "config after reset");
    ahb(STAT_ADDR, 1'b0, 32'h0000_0000, rd);
    check(rd, 32'h0000_0000, "status after reset");
    last_pos = 4'h0;
    run_step(16'h0007);
    $display("test mid-run reset done");
    results();
  end

endmodule : sequencer_step_config_tb

// *** design/ssc_ahb_slave.sv ***
// AHB-Lite slave front end: zero wait states, always OKAY.
// Assumes the register bank answers rd_data combinationally from rd_idx.
`timescale 1ns/1ps
`include "ssc_consts.svh"
module ssc_ahb_slave (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  ssc_reg_if.bus           rb
);
  // ==========================================================
  // Address phase decode
  wire       addr_take = hsel & htrans[1] & hready;
  wire       idx_ok    = (haddr[31:12] == 20'h0_0000);
  wire       rd_take   = addr_take & ~hwrite & idx_ok;

  logic       wr_pend_q;
  logic [9:0] wr_idx_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_idx_q  <= 10'h000;
    end else begin
      wr_pend_q <= addr_take & hwrite & idx_ok;
      wr_idx_q  <= haddr[11:2];
    end
  end

  // ==========================================================
  // Data phase
  assign rb.wr_en   = wr_pend_q;
  assign rb.wr_idx  = wr_idx_q;
  assign rb.wr_data = hwdata;
  assign rb.rd_idx  = haddr[11:2];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hrdata    <= rd_take ? rb.rd_data : 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end
endmodule : ssc_ahb_slave

// *** design/ssc_consts.svh ***
// Constants for the sequence step seven configuration block.
// Assumes inclusion by bare name from the design folder.
`ifndef SSC_CONSTS_SVH
`define SSC_CONSTS_SVH

// Register indices; byte address is four times the index
`define SSC_CFG_IDX       10'h097
`define SSC_STAT_IDX      10'h0A0
`define SSC_IDX_W         10

// Configuration register layout
`define SSC_CFG_RST       16'h0007
`define SSC_CFG_WMASK     16'hE01F
`define SSC_EN_BIT        15
`define SSC_GAIN_HI       14
`define SSC_GAIN_LO       13
`define SSC_NEG_BIT       4
`define SSC_POS_HI        3
`define SSC_POS_LO        0

// Positive input codes
`define SSC_POS_INT_MIN   4'h8
`define SSC_POS_TEMP      4'h8
`define SSC_POS_SHORT     4'h9
`define SSC_POS_IOSUP     4'hC

// Status register layout
`define SSC_ST_CONV_LO    0
`define SSC_ST_SKIP_LO    8
`define SSC_ST_BUSY_BIT   16
`define SSC_ST_LSKIP_BIT  17

`endif

// *** design/ssc_input_decode.sv ***
// Decodes a step configuration into mux selections and converter gain.
// Assumes a captured, stable configuration at its input.
`timescale 1ns/1ps
`include "ssc_consts.svh"
module ssc_input_decode (
  input  wire ssc_pkg::ssc_cfg_s cfg,
  output logic [3:0]             pos_sel,
  output logic                   neg_v7,
  output logic                   neg_auto,
  output logic                   temp_sel,
  output logic                   short_sel,
  output logic                   iosup_sel,
  output logic [1:0]             gain_log2
);
  // Gain codes 10b and 11b both mean four
  function automatic logic [1:0] gain_of(input logic [1:0] code);
    gain_of = code[1] ? 2'd2 : {1'b0, code[0]};
  endfunction : gain_of

  wire internal_src = (cfg.pos >= `SSC_POS_INT_MIN);

  assign pos_sel   = cfg.pos;
  assign neg_auto  = internal_src;
  assign neg_v7    = cfg.neg_v7 & ~internal_src;
  assign temp_sel  = (cfg.pos == `SSC_POS_TEMP);
  assign short_sel = (cfg.pos == `SSC_POS_SHORT);
  assign iosup_sel = (cfg.pos == `SSC_POS_IOSUP);
  assign gain_log2 = gain_of(cfg.gain);
endmodule : ssc_input_decode

// *** design/ssc_pkg.sv ***
// Types shared by the sequence step seven configuration block.
// Assumes nothing of its surroundings.
package ssc_pkg;

  typedef enum logic [0:0] {
    SSC_ST_IDLE = 1'b0,
    SSC_ST_CONV = 1'b1
  } ssc_state_e;

  typedef struct packed {
    logic       enable;
    logic [1:0] gain;
    logic       neg_v7;
    logic [3:0] pos;
  } ssc_cfg_s;

endpackage : ssc_pkg

// *** design/ssc_reg_if.sv ***
// Register access carrier between the bus slave and the register bank.
// Assumes one clock shared by both ends.
`timescale 1ns/1ps
interface ssc_reg_if;
  logic        wr_en;
  logic [9:0]  wr_idx;
  logic [31:0] wr_data;
  logic [9:0]  rd_idx;
  logic [31:0] rd_data;

  modport bus  (output wr_en, output wr_idx, output wr_data, output rd_idx, input rd_data);
  modport regs (input wr_en, input wr_idx, input wr_data, input rd_idx, output rd_data);
endinterface : ssc_reg_if

// *** design/ssc_step7_top.sv ***
// Step seven configuration register and step control for the multiplexed
// monitor converter sequencer, reached over AHB-Lite.
// Assumes seq_step_req and conv_done come from logic on hclk.
//
// Functional notes
// R1: Bit 15 includes step seven in the sequence when one and excludes it when zero, reset zero.
// R2: Bits 14:13 give gain 1 for 00b, gain 2 for 01b and gain 4 for 10b and 11b.
// R3: Bit 4 picks analog ground as negative input when zero and input seven when one.
// R4: Bits 3:0 codes 0000b to 0111b pick external voltage inputs zero to seven.
// R5: Codes from 1000b pick an internal source, choose the negative input and ignore bit 4.
// R6: Code 1000b picks the temperature sensor, 1001b a grounded short, 1100b io supply / 4.
// R7: A disabled step is skipped at once with no conversion and the sequence moves on.
//
// Design decisions made here: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ps
`include "ssc_consts.svh"
module ssc_step7_top (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        seq_step_req,
  input  wire logic        conv_done,
  output logic             conv_start,
  output logic             step_done,
  output logic             step_skipped,
  output logic             step_busy,
  output logic [3:0]       pos_input_sel,
  output logic             neg_v7_sel,
  output logic             neg_auto_sel,
  output logic             temp_sensor_sel,
  output logic             ground_short_sel,
  output logic             io_supply_sel,
  output logic [1:0]       gain_log2
);
  // ==========================================================
  // Assertion defaults
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // ==========================================================
  // Bus front end
  ssc_reg_if rb ();

  ssc_ahb_slave u_slave (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hwdata    (hwdata),
    .hready    (hready),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .hrdata    (hrdata),
    .rb        (rb)
  );

  // ==========================================================
  // Configuration register
  logic [15:0] cfg_q;
  wire         cfg_wr   = rb.wr_en & (rb.wr_idx == `SSC_CFG_IDX);
  wire  [15:0] cfg_wval = rb.wr_data[15:0] & `SSC_CFG_WMASK;
  wire  [15:0] cfg_d    = cfg_wr ? cfg_wval : cfg_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_q <= `SSC_CFG_RST; // R1
    end else begin
      cfg_q <= cfg_d;
    end
  end

  AST_CFG_KEEP: assert property ( // R1
    !cfg_wr |=> $stable(cfg_q))
    else $error("configuration changed without a write");

  ssc_pkg::ssc_cfg_s cfg_now;
  assign cfg_now.enable = cfg_q[`SSC_EN_BIT];
  assign cfg_now.gain   = cfg_q[`SSC_GAIN_HI:`SSC_GAIN_LO];
  assign cfg_now.neg_v7 = cfg_q[`SSC_NEG_BIT];
  assign cfg_now.pos    = cfg_q[`SSC_POS_HI:`SSC_POS_LO];

  // ==========================================================
  // Step control
  ssc_pkg::ssc_state_e state_q;
  ssc_pkg::ssc_state_e state_d;
  logic [7:0]  conv_cnt_q;
  logic [7:0]  skip_cnt_q;
  logic        last_skip_q;

  wire take_req  = seq_step_req & (state_q == ssc_pkg::SSC_ST_IDLE);
  wire take_conv = take_req & cfg_now.enable; // R1
  wire take_skip = take_req & ~cfg_now.enable; // R7
  wire conv_end  = (state_q == ssc_pkg::SSC_ST_CONV) & conv_done;

  always_comb begin
    state_d = state_q;
    case (state_q)
      ssc_pkg::SSC_ST_IDLE: begin
        if (take_conv) begin
          state_d = ssc_pkg::SSC_ST_CONV;
        end
      end
      ssc_pkg::SSC_ST_CONV: begin
        if (conv_done) begin
          state_d = ssc_pkg::SSC_ST_IDLE;
        end
      end
      default: begin
        state_d = ssc_pkg::SSC_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= ssc_pkg::SSC_ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      conv_start   <= 1'b0;
      step_done    <= 1'b0;
      step_skipped <= 1'b0;
      step_busy    <= 1'b0;
    end else begin
      conv_start   <= take_conv;
      step_done    <= take_skip | conv_end; // R7
      step_skipped <= take_skip; // R7
      step_busy    <= (state_d == ssc_pkg::SSC_ST_CONV);
    end
  end

  AST_DONE_AFTER_CONV: assert property ( // R1
    conv_end |=> step_done && !step_skipped && !step_busy)
    else $error("converted step did not finish");

  AST_BUSY_IGNORES_REQ: assert property ( // R1
    step_busy && seq_step_req |=> !conv_start && !step_skipped)
    else $error("request taken while busy");

  AST_START_PULSE: assert property ( // R1
    conv_start |=> !conv_start)
    else $error("conversion start longer than one cycle");

  AST_DONE_CAUSE: assert property ( // R7
    step_done |-> $past(take_skip) || $past(conv_end))
    else $error("step finished without a skip or a conversion end");

  AST_BUSY_HOLDS: assert property ( // R1
    step_busy && !conv_done |=> step_busy)
    else $error("conversion dropped before it ended");

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      conv_cnt_q  <= 8'h00;
      skip_cnt_q  <= 8'h00;
      last_skip_q <= 1'b0;
    end else begin
      if (take_conv) begin
        conv_cnt_q  <= conv_cnt_q + 8'h01;
        last_skip_q <= 1'b0;
      end
      if (take_skip) begin
        skip_cnt_q  <= skip_cnt_q + 8'h01;
        last_skip_q <= 1'b1;
      end
    end
  end

  AST_CONV_COUNT: assert property ( // R1
    take_conv |=> conv_cnt_q == $past(conv_cnt_q) + 8'h01)
    else $error("conversion count not advanced");

  AST_SKIP_COUNT: assert property ( // R7
    take_skip |=> skip_cnt_q == $past(skip_cnt_q) + 8'h01)
    else $error("skip count not advanced");

  // ==========================================================
  // Input selection; captured only when a conversion starts
  logic [3:0] dec_pos;
  logic       dec_neg_v7;
  logic       dec_neg_auto;
  logic       dec_temp;
  logic       dec_short;
  logic       dec_iosup;
  logic [1:0] dec_gain;

  ssc_input_decode u_dec (
    .cfg       (cfg_now),
    .pos_sel   (dec_pos),
    .neg_v7    (dec_neg_v7),
    .neg_auto  (dec_neg_auto),
    .temp_sel  (dec_temp),
    .short_sel (dec_short),
    .iosup_sel (dec_iosup),
    .gain_log2 (dec_gain)
  );

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pos_input_sel    <= 4'h0;
      neg_v7_sel       <= 1'b0;
      neg_auto_sel     <= 1'b0;
      temp_sensor_sel  <= 1'b0;
      ground_short_sel <= 1'b0;
      io_supply_sel    <= 1'b0;
      gain_log2        <= 2'd0;
    end else if (take_conv) begin
      pos_input_sel    <= dec_pos; // R4
      neg_v7_sel       <= dec_neg_v7; // R3
      neg_auto_sel     <= dec_neg_auto; // R5
      temp_sensor_sel  <= dec_temp; // R6
      ground_short_sel <= dec_short; // R6
      io_supply_sel    <= dec_iosup; // R6
      gain_log2        <= dec_gain; // R2
    end
  end

  AST_SKIP_KEEPS_SEL: assert property ( // R7
    take_skip |=> $stable(pos_input_sel) && $stable(neg_v7_sel) &&
      $stable(neg_auto_sel) && $stable(gain_log2))
    else $error("skipped step changed the input selection");

  AST_EXT_NO_INT: assert property ( // R4
    take_conv && !cfg_q[`SSC_POS_HI] |=>
      !temp_sensor_sel && !ground_short_sel && !io_supply_sel)
    else $error("external input raised an internal source select");

  AST_GAIN4_BOTH: assert property ( // R2
    take_conv && cfg_q[`SSC_GAIN_HI] |=> gain_log2 == 2'd2)
    else $error("gain code 1x did not give gain four");

  // ==========================================================
  // Register read back; a write in its data phase is forwarded
  wire [15:0] cfg_view = cfg_d;
  wire [31:0] stat_view;
  assign stat_view = {14'h0000, last_skip_q, step_busy, skip_cnt_q, conv_cnt_q};
  assign rb.rd_data = (rb.rd_idx == `SSC_CFG_IDX)  ? {16'h0000, cfg_view} :
                      (rb.rd_idx == `SSC_STAT_IDX) ? stat_view :
                      32'h0000_0000;

  // ==========================================================
  // Checks

  AST_EN_STARTS: assert property ( // R1
    take_req && cfg_q[`SSC_EN_BIT] |=> conv_start && !step_skipped && step_busy)
    else $error("enabled step did not start a conversion");

  AST_DIS_SKIPS: assert property ( // R7
    take_req && !cfg_q[`SSC_EN_BIT] |=> step_done && step_skipped && !conv_start)
    else $error("disabled step was not skipped");

  AST_NO_CONV_SKIP: assert property ( // R7
    step_skipped |-> !conv_start && !step_busy)
    else $error("skipped step started a conversion");

  AST_GAIN_MAP: assert property ( // R2
    take_conv |=> gain_log2 ==
      ($past(cfg_q[`SSC_GAIN_HI]) ? 2'd2 : {1'b0, $past(cfg_q[`SSC_GAIN_LO])}))
    else $error("gain code mapped wrongly");

  AST_NEG_SEL: assert property ( // R3
    take_conv && cfg_q[`SSC_POS_HI:`SSC_POS_LO] < `SSC_POS_INT_MIN
      |=> neg_v7_sel == $past(cfg_q[`SSC_NEG_BIT]) && !neg_auto_sel)
    else $error("negative input not taken from bit 4");

  AST_POS_EXT: assert property ( // R4
    take_conv |=> pos_input_sel == $past(cfg_q[`SSC_POS_HI:`SSC_POS_LO]))
    else $error("positive input select mismatch");

  AST_NEG_AUTO: assert property ( // R5
    take_conv && cfg_q[`SSC_POS_HI] |=> neg_auto_sel && !neg_v7_sel)
    else $error("internal source did not force automatic negative input");

  AST_INT_SRC: assert property ( // R6
    take_conv |=>
      temp_sensor_sel == ($past(cfg_q[`SSC_POS_HI:`SSC_POS_LO]) == `SSC_POS_TEMP) &&
      ground_short_sel == ($past(cfg_q[`SSC_POS_HI:`SSC_POS_LO]) == `SSC_POS_SHORT) &&
      io_supply_sel == ($past(cfg_q[`SSC_POS_HI:`SSC_POS_LO]) == `SSC_POS_IOSUP))
    else $error("internal source select mismatch");

  AST_SEL_HOLD: assert property ( // R4
    step_busy && !take_conv |=> $stable(pos_input_sel) && $stable(gain_log2))
    else $error("selection changed during conversion");

  AST_CFG_WRITE: assert property ( // R1
    cfg_wr |=> cfg_q == $past(cfg_wval))
    else $error("configuration write lost");

  COV_CONV: cover property (take_conv ##[1:20] conv_end);
  COV_SKIP: cover property (take_skip ##1 step_skipped);
  COV_INT:  cover property (take_conv && cfg_q[`SSC_POS_HI]);
  COV_WRRD: cover property (cfg_wr && rb.rd_idx == `SSC_CFG_IDX);
  COV_BUSY_REQ: cover property (step_busy && seq_step_req);
endmodule : ssc_step7_top
